/* File: rtl/pmbus_telemetry_command_bank.sv */
// Telemetry, limit and identification command bank with link-clock command port
// How it works
// (R1) Input overcurrent fault limit, stored, compared
// (R2) Input fault shuts down, no auto restart
// (R3) Input overcurrent warning limit raises warning
// (R4) Channel waits turn-on delay before rising
// (R5) Input power warning limit flags high power
// (R6) Live per-channel status and summary reads
// (R7) Return measured input voltage and current
// (R8) Return output voltage in VID form
// (R9) Return selected channel output current
// (R10) Return hottest power stage temperature
// (R11) Return output and input power
// (R12) Fixed bus specification revision code
// (R13) Maker and model fields returned unchanged
// (R14) Model revision and date, writable, stored
// (R15) Fixed part number code
// (R16) Fixed silicon revision code
// (R17) Image bytes read back, writes stored
// (R18) Read-only writes refused, communication flag set
// (R19) Stored values, except the input power warning limit, loaded after reset release
`timescale 1ns/1ps
`default_nettype none
module pmbus_telemetry_command_bank #(
  parameter int STAGES = 6,
  parameter int TON_CYC_PER_MS = pmbus_bank_pkg::CYC_PER_MS,
  parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] SIREV_CODE = 8'h01 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire pmbus_bank_pkg::cmd_t cmd,
  output logic busy,
  output logic rsp_valid,
  output pmbus_bank_pkg::rsp_t rsp,
  input wire pmbus_bank_pkg::in_meas_t in_meas,
  input wire pmbus_bank_pkg::ch_meas_t [1:0] ch_meas,
  input wire logic [1:0][STAGES-1:0][15:0] stage_temp,
  input wire logic [1:0] run_req,
  output logic [1:0] ramp,
  input wire pmbus_bank_pkg::nvm_image_t nvm_image,
  output pmbus_bank_pkg::nvm_wr_t nvm_wr
);
  import pmbus_bank_pkg::*;

  if (STAGES < 1 || STAGES > 16 || TON_CYC_PER_MS < 1) begin : g_bad_stages
    $error("STAGES or TON_CYC_PER_MS out of range");
  end

  // ****************************************
  // Number helpers
  // ****************************************
  // Linear mantissa/exponent to signed fixed point, 16 fraction bits
  function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0] sh;
    m = 48'(signed'(v[10:0]));
    sh = {1'b0, ~v[15], v[14:11]};
    return m <<< sh;
  endfunction

  // Delay code in ms to clock cycles; negative mantissa means no wait
  function automatic logic [39:0] ton_cyc(input logic [15:0] v);
    logic [39:0] p;
    p = v[10] ? 40'h0 : 40'(v[10:0]) * 40'(TON_CYC_PER_MS);
    return v[15] ? p >> (6'd32 - {1'b0, v[15:11]}) : p << v[14:11];
  endfunction

  // ****************************************
  // Link domain
  // ****************************************
  logic [1:0] lrst_sync_ff;
  logic lrstn;
  logic busy_ff;
  logic req_tgl_ff;
  cmd_t cmd_hold_ff;
  logic [2:0] ack_sync_ff;
  logic ack_edge;
  logic rsp_valid_ff;
  rsp_t rsp_ff;
  logic ack_tgl_ff;
  rsp_t rsp_hold_ff;

  always_ff @(posedge link_clk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], resetn};
  end
  assign lrstn = lrst_sync_ff[1];

  // Held request stays still until the answer returns, so the word crosses safely
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      cmd_hold_ff <= '0;
    end else if (cmd_valid && !busy_ff) begin
      busy_ff <= 1'b1;
      req_tgl_ff <= ~req_tgl_ff;
      cmd_hold_ff <= cmd;
    end else if (ack_edge) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      ack_sync_ff <= 3'h0;
    end else begin
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
    end
  end
  assign ack_edge = ack_sync_ff[2] ^ ack_sync_ff[1];

  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= ack_edge;
      if (ack_edge) begin
        rsp_ff <= rsp_hold_ff;
      end
    end
  end

  assign busy = busy_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;

  // ****************************************
  // Request crossing into system domain
  // ****************************************
  logic [2:0] req_sync_ff;
  logic req_fire;
  cmd_t c;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      req_sync_ff <= 3'h0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
    end
  end
  assign req_fire = req_sync_ff[2] ^ req_sync_ff[1];
  assign c = cmd_hold_ff;

  // ****************************************
  // Stored configuration
  // ****************************************
  logic load_ff;
  logic [15:0] inoc_flt_ff;
  logic [15:0] inoc_warn_ff;
  logic [15:0] pin_warn_ff;
  logic [1:0][15:0] ton_ff;
  logic [15:0] maker_ff;
  logic [15:0] model_ff;
  logic [15:0] mrev_ff;
  logic [15:0] mdate_ff;
  logic [7:0] img0_ff;
  logic [7:0] img1_ff;
  logic [7:0] in_st_ff;
  logic [7:0] com_st_ff;
  logic [1:0][15:0] hot_ff;
  logic [1:0] ramp_ff;
  nvm_wr_t nvm_wr_ff;
  logic [31:0] rd_data;
  logic known;
  logic ro;
  logic backed;
  logic wr_go;
  logic [7:0] sb;
  logic [15:0] sw;

  // Image is caught one edge after release, never under reset itself
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      load_ff <= 1'b1;
    end else begin
      load_ff <= 1'b0;
    end
  end

  assign wr_go = req_fire && c.write && known && !ro;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      inoc_flt_ff <= RST_INOC_LIM;
      inoc_warn_ff <= RST_INOC_LIM;
      pin_warn_ff <= RST_PIN_WARN;
      ton_ff <= {RST_TON, RST_TON};
      maker_ff <= 16'h0;
      model_ff <= 16'h0;
      mrev_ff <= 16'h0;
      mdate_ff <= 16'h0;
      img0_ff <= 8'h0;
      img1_ff <= 8'h0;
    end else if (load_ff) begin
      inoc_flt_ff <= nvm_image.inoc_flt; // R19
      inoc_warn_ff <= nvm_image.inoc_warn;
      ton_ff <= {nvm_image.ton1, nvm_image.ton0};
      maker_ff <= nvm_image.maker;
      model_ff <= nvm_image.model;
      mrev_ff <= nvm_image.mrev;
      mdate_ff <= nvm_image.mdate;
      img0_ff <= nvm_image.img0;
      img1_ff <= nvm_image.img1;
    end else if (wr_go) begin
      case (c.code)
        CMD_INOC_FLT: inoc_flt_ff <= c.data[15:0]; // R1
        CMD_INOC_WARN: inoc_warn_ff <= c.data[15:0]; // R3
        CMD_PIN_WARN: pin_warn_ff <= c.data[15:0]; // R5
        CMD_TON: ton_ff[c.page] <= c.data[15:0]; // R4
        CMD_MAKER: maker_ff <= c.data[15:0]; // R13
        CMD_MODEL: model_ff <= c.data[15:0]; // R13
        CMD_MREV: mrev_ff <= c.data[15:0]; // R14
        CMD_MDATE: mdate_ff <= c.data[15:0]; // R14
        CMD_IMG0: img0_ff <= c.data[7:0]; // R17
        CMD_IMG1: img1_ff <= c.data[7:0]; // R17
        default: ;
      endcase
    end
  end

  // Every accepted write to a stored command except the input power warning limit goes out to the NVM port
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      nvm_wr_ff <= '0;
    end else begin
      nvm_wr_ff.valid <= wr_go && backed; // R17
      nvm_wr_ff.page <= c.page;
      nvm_wr_ff.code <= c.code;
      nvm_wr_ff.data <= c.data[15:0];
    end
  end
  assign nvm_wr = nvm_wr_ff;

  // ****************************************
  // Input limit checks and sticky flags
  // ****************************************
  logic oc_flt_hit;
  logic oc_warn_hit;
  logic pin_hit;
  logic [7:0] set_in;
  logic [7:0] set_com;
  logic [7:0] clr_in;
  logic [7:0] clr_com;

  assign oc_flt_hit = lin_fix(in_meas.iin) > lin_fix(inoc_flt_ff); // R1
  assign oc_warn_hit = lin_fix(in_meas.iin) > lin_fix(inoc_warn_ff); // R3
  assign pin_hit = lin_fix(in_meas.pin) > lin_fix(pin_warn_ff); // R5

  always_comb begin
    set_in = 8'h0;
    set_in[B_IN_OC_FLT] = oc_flt_hit;
    set_in[B_IN_OC_WARN] = oc_warn_hit;
    set_in[B_IN_PIN_WARN] = pin_hit;
    set_com = 8'h0;
    set_com[B_COM_BAD_CMD] = req_fire && !known;
    set_com[B_COM_OTHER] = req_fire && c.write && known && ro; // R18
    clr_in = (wr_go && c.code == CMD_ST_IN) ? c.data[7:0] : 8'h0;
    clr_com = (wr_go && c.code == CMD_ST_COM) ? c.data[7:0] : 8'h0;
  end

  // Writing ones clears; a new event in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      in_st_ff <= 8'h0;
      com_st_ff <= 8'h0;
    end else begin
      in_st_ff <= (in_st_ff & ~clr_in) | set_in;
      com_st_ff <= (com_st_ff & ~clr_com) | set_com;
    end
  end

  // ****************************************
  // Channels: start sequencing and hottest stage
  // ****************************************
  for (genvar g = 0; g < 2; g++) begin : g_ch
    ch_state_t st_ff;
    logic [39:0] cnt_ff;
    logic run_q_ff;
    logic ok;
    logic [15:0] nxt_hot;

    // Shutdown latches through the sticky flag; only a fresh start edge restarts
    assign ok = run_req[g] && !in_st_ff[B_IN_OC_FLT]; // R2

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        run_q_ff <= 1'b0;
      end else begin
        run_q_ff <= run_req[g];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        st_ff <= CH_IDLE;
        cnt_ff <= 40'h0;
      end else if (!ok) begin
        st_ff <= CH_IDLE; // R2
      end else begin
        unique case (st_ff)
          CH_IDLE: if (!run_q_ff) begin
            st_ff <= CH_WAIT;
            cnt_ff <= ton_cyc(ton_ff[g]); // R4
          end
          CH_WAIT: if (cnt_ff == 40'h0) begin
            st_ff <= CH_ON;
          end else begin
            cnt_ff <= cnt_ff - 40'h1; // R4
          end
          CH_ON: ;
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        ramp_ff[g] <= 1'b0;
      end else begin
        ramp_ff[g] <= ok && (st_ff == CH_ON || (st_ff == CH_WAIT && cnt_ff == 40'h0)); // R4
      end
    end

    always_comb begin
      nxt_hot = stage_temp[g][0];
      for (int s = 1; s < STAGES; s++) begin
        if (lin_fix(stage_temp[g][s]) > lin_fix(nxt_hot)) begin
          nxt_hot = stage_temp[g][s]; // R10
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        hot_ff[g] <= 16'h0;
      end else begin
        hot_ff[g] <= nxt_hot;
      end
    end
  end
  assign ramp = ramp_ff;

  // ****************************************
  // Command decode and read data
  // ****************************************
  always_comb begin
    ch_meas_t m;
    m = ch_meas[c.page];
    sb = 8'h0;
    sb[B_SB_OFF] = !ramp_ff[c.page];
    sb[B_SB_IOUT] = m.st_io[7];
    sb[B_SB_TEMP] = |m.st_tmp;
    sb[B_SB_COM] = |com_st_ff;
    sw = {8'h0, sb};
    sw[B_SW_VOUT] = |m.st_vo;
    sw[B_SW_IOUT] = |m.st_io;
    sw[B_SW_INPUT] = |in_st_ff;
    sw[B_SW_VND] = |m.st_vnd;
    rd_data = 32'h0;
    known = 1'b1;
    ro = 1'b1;
    backed = 1'b0;
    case (c.code)
      CMD_INOC_FLT: begin rd_data[15:0] = inoc_flt_ff; ro = 1'b0; backed = 1'b1; end
      CMD_INOC_ACT: rd_data[7:0] = INOC_ACTION; // R2
      CMD_INOC_WARN: begin rd_data[15:0] = inoc_warn_ff; ro = 1'b0; backed = 1'b1; end
      CMD_TON: begin rd_data[15:0] = ton_ff[c.page]; ro = 1'b0; backed = 1'b1; end
      CMD_PIN_WARN: begin rd_data[15:0] = pin_warn_ff; ro = 1'b0; end
      CMD_SUM_BYTE: begin rd_data[7:0] = sb; ro = 1'b0; end // R6
      CMD_SUM_WORD: begin rd_data[15:0] = sw; ro = 1'b0; end // R6
      CMD_ST_VO: begin rd_data[7:0] = m.st_vo; ro = 1'b0; end // R6
      CMD_ST_IO: begin rd_data[7:0] = m.st_io; ro = 1'b0; end // R6
      CMD_ST_IN: begin rd_data[7:0] = in_st_ff; ro = 1'b0; end // R6
      CMD_ST_TMP: begin rd_data[7:0] = m.st_tmp; ro = 1'b0; end // R6
      CMD_ST_COM: begin rd_data[7:0] = com_st_ff; ro = 1'b0; end // R6
      CMD_ST_VND: begin rd_data[7:0] = m.st_vnd; ro = 1'b0; end // R6
      CMD_M_VIN: rd_data[15:0] = in_meas.vin; // R7
      CMD_M_IIN: rd_data[15:0] = in_meas.iin; // R7
      CMD_M_VOUT: rd_data[15:0] = m.vout_vid; // R8
      CMD_M_IOUT: rd_data[15:0] = m.iout; // R9
      CMD_M_TEMP: rd_data[15:0] = hot_ff[c.page]; // R10
      CMD_M_POUT: rd_data[15:0] = m.pout; // R11
      CMD_M_PIN: rd_data[15:0] = in_meas.pin; // R11
      CMD_SPEC_REV: rd_data[7:0] = SPEC_REV_CODE; // R12
      CMD_MAKER: begin rd_data[15:0] = maker_ff; ro = 1'b0; backed = 1'b1; end // R13
      CMD_MODEL: begin rd_data[15:0] = model_ff; ro = 1'b0; backed = 1'b1; end // R13
      CMD_MREV: begin rd_data[15:0] = mrev_ff; ro = 1'b0; backed = 1'b1; end // R14
      CMD_MDATE: begin rd_data[15:0] = mdate_ff; ro = 1'b0; backed = 1'b1; end // R14
      CMD_CKSUM: rd_data = CKSUM_VAL;
      CMD_PART: rd_data[7:0] = PART_CODE; // R15
      CMD_SIREV: rd_data[7:0] = SIREV_CODE; // R16
      CMD_IMG0: begin rd_data[7:0] = img0_ff; ro = 1'b0; backed = 1'b1; end // R17
      CMD_IMG1: begin rd_data[7:0] = img1_ff; ro = 1'b0; backed = 1'b1; end // R17
      default: known = 1'b0;
    endcase
  end

  // Answer stays in the holding word until the next request overwrites it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_tgl_ff <= 1'b0;
      rsp_hold_ff <= '0;
    end else if (req_fire) begin
      ack_tgl_ff <= ~ack_tgl_ff;
      rsp_hold_ff.ok <= known && !(c.write && ro); // R18
      rsp_hold_ff.data <= c.write ? 32'h0 : rd_data;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd(logic [7:0] k);
    req_fire && !c.write && c.code == k;
  endsequence

  sequence s_start0;
    g_ch[0].st_ff == CH_IDLE && g_ch[0].ok && !g_ch[0].run_q_ff && ton_cyc(ton_ff[0]) > 40'h3;
  endsequence

  a_oc_fault_flag: assert property (oc_flt_hit |=> in_st_ff[B_IN_OC_FLT]) // R1
    else $error("input fault flag missed");
  a_fault_forces_off: assert property (in_st_ff[B_IN_OC_FLT] |=> ramp_ff == 2'b00) // R2
    else $error("output kept on after input fault");
  a_oc_warn_flag: assert property (oc_warn_hit |=> in_st_ff[B_IN_OC_WARN]) // R3
    else $error("input warning flag missed");
  a_ton_holds_low: assert property (s_start0 |=> !ramp_ff[0] [*3]) // R4
    else $error("output rose before delay");
  a_pin_warn_flag: assert property (pin_hit |=> in_st_ff[B_IN_PIN_WARN]) // R5
    else $error("input power flag missed");
  a_vin_readback: assert property (s_rd(CMD_M_VIN) |=> rsp_hold_ff.data[15:0] == $past(in_meas.vin)) // R7
    else $error("wrong input voltage answer");
  a_spec_rev_code: assert property (s_rd(CMD_SPEC_REV) |=> rsp_hold_ff.data == {24'h0, SPEC_REV_CODE}) // R12
    else $error("wrong revision answer");
  a_img_store: assert property (req_fire && c.write && c.code == CMD_IMG0 && !load_ff
    |=> nvm_wr_ff.valid && img0_ff == $past(c.data[7:0])) // R17
    else $error("image write not stored");
  a_ro_write_refused: assert property (req_fire && c.write && c.code == CMD_M_IOUT
    |=> !rsp_hold_ff.ok && com_st_ff[B_COM_OTHER] && !nvm_wr_ff.valid) // R18
    else $error("read-only write not refused");
  a_nvm_power_load: assert property (load_ff |=> inoc_flt_ff == $past(nvm_image.inoc_flt)) // R19
    else $error("stored limit not loaded");
endmodule
`default_nettype wire

/* File: rtl/pmbus_bank_pkg.sv */
// Command codes, fields, defaults and carriers of the telemetry command bank
package pmbus_bank_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_INOC_FLT = 8'h5b;
  localparam logic [7:0] CMD_INOC_ACT = 8'h5c;
  localparam logic [7:0] CMD_INOC_WARN = 8'h5d;
  localparam logic [7:0] CMD_TON = 8'h60;
  localparam logic [7:0] CMD_PIN_WARN = 8'h6b;
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_ST_VO = 8'h7a;
  localparam logic [7:0] CMD_ST_IO = 8'h7b;
  localparam logic [7:0] CMD_ST_IN = 8'h7c;
  localparam logic [7:0] CMD_ST_TMP = 8'h7d;
  localparam logic [7:0] CMD_ST_COM = 8'h7e;
  localparam logic [7:0] CMD_ST_VND = 8'h80;
  localparam logic [7:0] CMD_M_VIN = 8'h88;
  localparam logic [7:0] CMD_M_IIN = 8'h89;
  localparam logic [7:0] CMD_M_VOUT = 8'h8b;
  localparam logic [7:0] CMD_M_IOUT = 8'h8c;
  localparam logic [7:0] CMD_M_TEMP = 8'h8d;
  localparam logic [7:0] CMD_M_POUT = 8'h96;
  localparam logic [7:0] CMD_M_PIN = 8'h97;
  localparam logic [7:0] CMD_SPEC_REV = 8'h98;
  localparam logic [7:0] CMD_MAKER = 8'h99;
  localparam logic [7:0] CMD_MODEL = 8'h9a;
  localparam logic [7:0] CMD_MREV = 8'h9b;
  localparam logic [7:0] CMD_MDATE = 8'h9d;
  localparam logic [7:0] CMD_CKSUM = 8'h9e;
  localparam logic [7:0] CMD_PART = 8'had;
  localparam logic [7:0] CMD_SIREV = 8'hae;
  localparam logic [7:0] CMD_IMG0 = 8'hb0;
  localparam logic [7:0] CMD_IMG1 = 8'hb1;
  // ****************************************
  // Defaults and fixed codes
  // ****************************************
  localparam logic [15:0] RST_INOC_LIM = 16'hf87f;
  localparam logic [15:0] RST_TON = 16'hc26e;
  localparam logic [15:0] RST_PIN_WARN = 16'h08e1;
  localparam logic [7:0] INOC_ACTION = 8'hc0;
  localparam logic [7:0] SPEC_REV_CODE = 8'h33;
  localparam logic [31:0] CKSUM_VAL = 32'h484d2979;
  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int B_IN_OC_FLT = 2;
  localparam int B_IN_OC_WARN = 1;
  localparam int B_IN_PIN_WARN = 0;
  localparam int B_COM_BAD_CMD = 7;
  localparam int B_COM_OTHER = 1;
  localparam int B_SB_OFF = 6;
  localparam int B_SB_IOUT = 4;
  localparam int B_SB_TEMP = 2;
  localparam int B_SB_COM = 1;
  localparam int B_SW_VOUT = 15;
  localparam int B_SW_IOUT = 14;
  localparam int B_SW_INPUT = 13;
  localparam int B_SW_VND = 12;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PS_PER_MS = 1000000000;
  localparam int CYC_PER_MS = PS_PER_MS / CLK_PERIOD_PS;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {CH_IDLE = 3'b001, CH_WAIT = 3'b010, CH_ON = 3'b100} ch_state_t;
  typedef struct packed {logic write; logic page; logic [7:0] code; logic [31:0] data;} cmd_t;
  typedef struct packed {logic ok; logic [31:0] data;} rsp_t;
  typedef struct packed {logic [15:0] vin; logic [15:0] iin; logic [15:0] pin;} in_meas_t;
  typedef struct packed {
    logic [15:0] vout_vid; logic [15:0] iout; logic [15:0] pout;
    logic [7:0] st_vo; logic [7:0] st_io; logic [7:0] st_tmp; logic [7:0] st_vnd;
  } ch_meas_t;
  typedef struct packed {
    logic [15:0] inoc_flt; logic [15:0] inoc_warn; logic [15:0] ton0; logic [15:0] ton1;
    logic [15:0] maker; logic [15:0] model; logic [15:0] mrev; logic [15:0] mdate;
    logic [7:0] img0; logic [7:0] img1;
  } nvm_image_t;
  typedef struct packed {logic valid; logic page; logic [7:0] code; logic [15:0] data;} nvm_wr_t;
endpackage

/* File: test/pmbus_host_model.sv */
// Host-side model that issues requests on the link-clock command port
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model
  import pmbus_bank_pkg::*;
(
  input wire logic link_clk,
  input wire logic busy,
  input wire logic rsp_valid,
  output logic cmd_valid,
  output pmbus_bank_pkg::cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // ****************************************
  // Request task
  // ****************************************
  // Busy only moves on a rising edge, so its value at the prior falling edge is the one sampled
  task automatic xfer(input cmd_t c, output logic done);
    logic b;
    done = 1'b0;
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = c;
    for (int i = 0; i < 40 && !done; i++) begin
      @(negedge link_clk);
      b = busy;
      @(posedge link_clk);
      done = (b === 1'b0);
    end
    #1;
    cmd_valid = 1'b0;
    // Released bus shows a scrambled value, never the stale request
    cmd = ~c;
    if (done) begin
      done = 1'b0;
      for (int i = 0; i < 40 && !done; i++) begin
        @(negedge link_clk);
        done = (rsp_valid === 1'b1);
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the telemetry command bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmbus_bank_pkg::*;
  localparam int TSCALE = 20;
  localparam logic [7:0] ST[9] = '{CMD_INOC_FLT, CMD_INOC_WARN, CMD_TON, CMD_MAKER, CMD_MODEL, CMD_MREV,
                                   CMD_MDATE, CMD_IMG0, CMD_IMG1};
  localparam logic [7:0] WC[6] = '{CMD_MAKER, CMD_MODEL, CMD_MREV, CMD_MDATE, CMD_IMG0, CMD_IMG1};
  localparam logic [7:0] RO[12] = '{CMD_INOC_ACT, CMD_M_VIN, CMD_M_IIN, CMD_M_VOUT, CMD_M_IOUT, CMD_M_TEMP,
                                    CMD_M_POUT, CMD_M_PIN, CMD_SPEC_REV, CMD_CKSUM, CMD_PART, CMD_SIREV};
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid, busy, rsp_valid;
  cmd_t cmd;
  rsp_t rsp;
  in_meas_t in_meas = '0;
  ch_meas_t [1:0] ch_meas = '0;
  logic [1:0][5:0][15:0] stage_temp = '0;
  logic [1:0] run_req = 2'b00;
  logic [1:0] ramp;
  nvm_image_t img = '0;
  nvm_wr_t nvm_wr;
  rsp_t exp_q[$];
  logic [24:0] nvm_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int wr_seen = 0;
  int wr_exp = 0;
  always #2.5 sys_clk = ~sys_clk;
  // Link clock offset so its edges never line up with the system clock
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  pmbus_telemetry_command_bank #(.STAGES(6), .TON_CYC_PER_MS(TSCALE), .PART_CODE(8'h3c), .SIREV_CODE(8'h02))
  i_pmbus_telemetry_command_bank (.sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp), .in_meas(in_meas),
    .ch_meas(ch_meas), .stage_temp(stage_temp), .run_req(run_req), .ramp(ramp), .nvm_image(img),
    .nvm_wr(nvm_wr));
  pmbus_host_model i_pmbus_host_model (.link_clk(link_clk), .busy(busy), .rsp_valid(rsp_valid),
    .cmd_valid(cmd_valid), .cmd(cmd));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    tests_run++;
    if (seen !== expv) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(negedge link_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(rsp, '1);
      else check(rsp, exp_q.pop_front());
    end
  end
  always @(negedge sys_clk) begin
    if (nvm_wr.valid === 1'b1) begin
      wr_seen++;
      if (nvm_q.size() > 0) check(33'({nvm_wr.page, nvm_wr.code, nvm_wr.data}), 33'(nvm_q.pop_front()));
    end
  end
  task automatic op(input logic w, input logic pg, input logic [7:0] code, input logic [31:0] d, input logic ok,
                    input logic [31:0] e);
    logic done;
    exp_q.push_back({ok, e});
    if (w && ok && (code inside {ST})) begin
      wr_exp++;
      nvm_q.push_back({pg, code, d[15:0]});
    end
    i_pmbus_host_model.xfer({w, pg, code, d}, done);
    if (!done) begin
      check(1'b0, 1'b1);
      summarize();
    end
  endtask
  task automatic rd(input logic pg, input logic [7:0] code, input logic [31:0] e);
    op(1'b0, pg, code, 32'h0, 1'b1, e);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [223:0] r;
    logic [15:0] tmax [2];
    logic [7:0] sbx;
    int n;
    int exp_n;
    void'($urandom(1));
    img = {$urandom(), $urandom(), $urandom(), $urandom(), 16'($urandom())};
    img.inoc_flt = 16'hf87f;
    img.inoc_warn = 16'hf87f;
    img.ton0 = 16'hc26e;
    // One millisecond on the second channel keeps its wait short
    img.ton1 = 16'h0001;
    in_meas = {$urandom(), 16'h0010};
    in_meas.iin = 16'h0010;
    r = '0;
    repeat (7) r = {r[191:0], $urandom()};
    ch_meas = r;
    for (int p = 0; p < 2; p++) begin
      tmax[p] = 16'h0;
      for (int s = 0; s < 6; s++) begin
        stage_temp[p][s] = 16'($urandom_range(0, 255));
        if (stage_temp[p][s] > tmax[p]) tmax[p] = stage_temp[p][s];
      end
    end
    // Link reset passes a two-flop sync, so reset spans several link periods
    repeat (70) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge link_clk);
    rd(1'b0, CMD_INOC_FLT, {16'h0, img.inoc_flt});
    rd(1'b0, CMD_INOC_WARN, {16'h0, img.inoc_warn});
    rd(1'b0, CMD_TON, {16'h0, img.ton0});
    rd(1'b1, CMD_TON, {16'h0, img.ton1});
    rd(1'b0, CMD_MAKER, {16'h0, img.maker});
    rd(1'b0, CMD_MODEL, {16'h0, img.model});
    rd(1'b0, CMD_MREV, {16'h0, img.mrev});
    rd(1'b0, CMD_MDATE, {16'h0, img.mdate});
    rd(1'b0, CMD_IMG0, {24'h0, img.img0});
    rd(1'b1, CMD_IMG1, {24'h0, img.img1});
    rd(1'b0, CMD_PIN_WARN, 32'h08e1);
    rd(1'b0, CMD_INOC_ACT, 32'hc0);
    rd(1'b0, CMD_SPEC_REV, 32'h33);
    rd(1'b0, CMD_CKSUM, 32'h484d2979);
    rd(1'b0, CMD_PART, 32'h3c);
    rd(1'b1, CMD_SIREV, 32'h02);
    foreach (WC[k]) begin
      d = (WC[k] >= CMD_IMG0) ? 32'($urandom_range(0, 255)) : 32'($urandom_range(0, 65535));
      op(1'b1, 1'b0, WC[k], d, 1'b1, 32'h0);
      rd(1'b1, WC[k], d);
    end
    foreach (RO[k]) op(1'b1, 1'b0, RO[k], 32'h000000ff, 1'b0, 32'h0);
    // Output voltage status writes are taken but leave the live value untouched
    op(1'b1, 1'b0, CMD_ST_VO, 32'h000000ff, 1'b1, 32'h0);
    rd(1'b0, CMD_INOC_ACT, 32'hc0);
    rd(1'b0, CMD_ST_COM, 32'h02);
    op(1'b1, 1'b0, CMD_ST_COM, 32'h02, 1'b1, 32'h0);
    op(1'b0, 1'b0, 8'h5e, 32'h0, 1'b0, 32'h0);
    rd(1'b0, CMD_ST_COM, 32'h80);
    rd(1'b0, CMD_M_VIN, {16'h0, in_meas.vin});
    rd(1'b0, CMD_M_IIN, {16'h0, in_meas.iin});
    rd(1'b0, CMD_M_PIN, {16'h0, in_meas.pin});
    for (int p = 0; p < 2; p++) begin
      rd(p[0], CMD_M_VOUT, {16'h0, ch_meas[p].vout_vid});
      rd(p[0], CMD_M_IOUT, {16'h0, ch_meas[p].iout});
      rd(p[0], CMD_M_POUT, {16'h0, ch_meas[p].pout});
      rd(p[0], CMD_M_TEMP, {16'h0, tmax[p]});
      rd(p[0], CMD_ST_VO, {24'h0, ch_meas[p].st_vo});
      rd(p[0], CMD_ST_IO, {24'h0, ch_meas[p].st_io});
      rd(p[0], CMD_ST_TMP, {24'h0, ch_meas[p].st_tmp});
      rd(p[0], CMD_ST_VND, {24'h0, ch_meas[p].st_vnd});
      // Both channels off, no input flags, bad-command flag still up
      sbx = {1'b0, 1'b1, 1'b0, ch_meas[p].st_io[7], 1'b0, |ch_meas[p].st_tmp, 1'b1, 1'b0};
      rd(p[0], CMD_SUM_BYTE, {24'h0, sbx});
      rd(p[0], CMD_SUM_WORD, {16'h0, |ch_meas[p].st_vo, |ch_meas[p].st_io, 1'b0, |ch_meas[p].st_vnd, 4'h0, sbx});
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      #1 run_req[p] = 1'b1;
      n = 0;
      while (ramp[p] !== 1'b1 && n < 300) begin
        @(posedge sys_clk);
        #1 n++;
      end
      exp_n = (p == 1) ? TSCALE + 2 : ((622 * TSCALE) / 256) + 2;
      check(33'(n >= exp_n - 1 && n <= exp_n + 1), 33'h1);
      if (n >= 300) summarize();
    end
    // Exactly at the limits is not above them
    #1 in_meas.iin = 16'hf87f;
    in_meas.pin = 16'h08e1;
    repeat (6) @(posedge sys_clk);
    #1 check({31'h0, ramp}, 33'h3);
    rd(1'b0, CMD_ST_IN, 32'h0);
    in_meas.iin = 16'h0040;
    in_meas.pin = 16'h01c3;
    repeat (6) @(posedge sys_clk);
    #1 check({31'h0, ramp}, 33'h0);
    rd(1'b0, CMD_ST_IN, 32'h07);
    in_meas.iin = 16'h0010;
    in_meas.pin = 16'h0010;
    op(1'b1, 1'b0, CMD_ST_IN, 32'h07, 1'b1, 32'h0);
    rd(1'b0, CMD_ST_IN, 32'h0);
    check({31'h0, ramp}, 33'h0);
    repeat (4) @(posedge link_clk);
    check(33'(exp_q.size()), 33'h0);
    check(33'(wr_seen), 33'(wr_exp));
    summarize();
  end
endmodule
`default_nettype wire
